// [level_vector_interrupt_router.sv]
`timescale 1ns/1ps
// How it works
// R1: Twelve maskable sources, each with own vector.
// R2: Eight levels; timers share 0, pins 1.4-1.7 share 7.
// R3: Between levels the priority register decides.
// R4: Inside a level lowest vector wins, fixed.
// R5: Vectors F0,F2,F4,F6 and E0..EE for pins.
// R6: Rank zero is highest inside a level.
// R7: Grant blocks other interrupts during stack push.
// R8: Start address is vector byte plus next byte.
// R9: Any reset starts execution at 0100H.
// R10: Global enable instruction starts interrupt servicing.
// R11: Global disable stops servicing at once.
// R12: Both instructions only write mode bit 0.
// R13: Startup software must issue the enable instruction.
// R14: Reset clears global and fast enable bits.
// R15: Mask bit zero masks a level, one passes.
// R16: Request register shows one flag per level.
// R17: Level request is OR of enabled pending sources.
// R18: Arbiter picks only pending, unmasked, globally enabled.
module level_vector_interrupt_router
  import lvir_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  input wire logic basicTimerReset,
  // Internal source events and controls
  input wire logic [3:0] periphEvent,
  input wire logic [NUM_SRC-1:0] sourceEnable,
  input wire logic [NUM_SRC-1:0] pendingClear,
  // External interrupt pins and edge choice
  input wire logic [7:0] extPin,
  input wire logic [7:0] pinRisingEdge,
  // Register writes from the core
  input wire logic maskWrite,
  input wire logic [NUM_LVL-1:0] maskData,
  input wire logic priorityWrite,
  input wire logic [NUM_LVL*RANK_W-1:0] priorityData,
  input wire logic modeWrite,
  input wire logic [SYM_W-1:0] modeData,
  input wire logic globalEnableInstr,
  input wire logic globalDisableInstr,
  // Core handshake
  input wire logic irqAck,
  input wire logic stackDone,
  input wire logic [7:0] romData,
  // Register views
  output logic [NUM_LVL-1:0] levelMask,
  output logic [NUM_LVL*RANK_W-1:0] levelPriority,
  output logic [SYM_W-1:0] systemMode,
  output logic [NUM_LVL-1:0] levelRequest,
  output logic [NUM_SRC-1:0] sourcePending,
  // Core side outputs
  output logic irqRequest,
  output logic [7:0] irqVector,
  output logic [2:0] irqLevel,
  output logic intBlocked,
  output logic romRead,
  output logic [15:0] romAddr,
  output logic pcLoad,
  output logic [15:0] pcValue
);
  lvir_state_t state;
  logic [7:0] pinS1, pinS2, pinS3, pinLevel;
  logic [7:0] pinEvent;
  logic [NUM_SRC-1:0] srcEvent;
  logic [NUM_SRC-1:0] activeSrc;
  logic [NUM_LVL-1:0] next_levelRequest;
  logic winValid;
  logic [2:0] winLevel;
  logic [3:0] winSrc;
  logic [7:0] grantVector;
  logic [7:0] addrHi;
  logic bootPending;

  // Three-stage pin synchroniser; the first stage feeds only the second
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pinS1 <= 8'h00;
      pinS2 <= 8'h00;
      pinS3 <= 8'h00;
    end else begin
      pinS1 <= extPin;
      pinS2 <= pinS1;
      pinS3 <= pinS2;
    end
  end

  // Settled pin level, taken only when stages two and three agree
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pinLevel <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (pinS2[i] == pinS3[i]) begin
          pinLevel[i] <= pinS3[i];
        end
      end
    end
  end

  // Edge of the chosen polarity on a settled pin
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pinEvent[i] = (pinS2[i] == pinS3[i]) && (pinS3[i] != pinLevel[i])
        && (pinS3[i] == pinRisingEdge[i]);
    end
  end

  assign srcEvent = {pinEvent, periphEvent}; // R1

  // Sticky pending per source, cleared by software; a new event beats the clear
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sourcePending <= '0;
    end else begin
      sourcePending <= (sourcePending & ~pendingClear) | srcEvent; // R17
    end
  end

  // Level request is the OR of the enabled pending sources of that level
  always_comb begin
    activeSrc = sourcePending & sourceEnable;
    next_levelRequest = '0;
    for (int s = 0; s < NUM_SRC; s++) begin
      if (activeSrc[s]) begin
        next_levelRequest[lvir_level_of(4'(s))] = 1'b1; // R2 R17
      end
    end
  end

  // Request register, one flag per level
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      levelRequest <= '0;
    end else begin
      levelRequest <= next_levelRequest; // R16
    end
  end

  // Level mask register
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      levelMask <= MASK_RESET;
    end else if (maskWrite) begin
      levelMask <= maskData;
    end
  end

  // Level priority register: one rank per level
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      levelPriority <= PRIO_RESET;
    end else if (priorityWrite) begin
      levelPriority <= priorityData;
    end
  end

  // System mode; the instructions touch only the global enable bit
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      systemMode <= SYM_RESET; // R14
    end else if (basicTimerReset) begin
      systemMode <= SYM_RESET; // R14
    end else if (globalDisableInstr) begin
      systemMode[SYM_GLOBAL_EN] <= 1'b0; // R11 R12
    end else if (globalEnableInstr) begin
      systemMode[SYM_GLOBAL_EN] <= 1'b1; // R10 R12 R13
    end else if (modeWrite) begin
      systemMode <= modeData;
    end
  end

  // Level arbitration over pending and unmasked levels
  lvir_level_pick levelPick (
    .request(levelRequest & levelMask), // R15 R18
    .rank(levelPriority), // R3
    .valid(winValid),
    .level(winLevel)
  );

  // Fixed order inside the winning level: lowest source index, lowest vector
  always_comb begin
    winSrc = 4'h0;
    for (int s = NUM_SRC - 1; s >= 0; s--) begin
      if (activeSrc[s] && lvir_level_of(4'(s)) == winLevel) begin
        winSrc = 4'(s); // R4 R6
      end
    end
  end

  // Request to the core, dropped at once when disabled or busy
  always_ff @(posedge clock) begin
    if (!rst_b || basicTimerReset) begin
      irqRequest <= 1'b0;
      irqVector <= 8'h00;
      irqLevel <= 3'h0;
    end else if (state == ST_IDLE && !(irqRequest && irqAck)) begin
      irqRequest <= winValid && systemMode[SYM_GLOBAL_EN]; // R18 R10 R11
      irqVector <= lvir_vector_of(winSrc); // R5
      irqLevel <= winLevel;
    end else begin
      irqRequest <= 1'b0; // R7
    end
  end

  // Grant sequence: block, push, fetch two vector bytes, start routine
  always_ff @(posedge clock) begin
    if (!rst_b || basicTimerReset) begin
      state <= ST_IDLE;
      grantVector <= 8'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          if (irqRequest && irqAck && systemMode[SYM_GLOBAL_EN]) begin
            state <= ST_PUSH;
            grantVector <= irqVector;
          end
        end
        ST_PUSH: begin
          if (stackDone) begin
            state <= ST_READ_HI; // R7
          end
        end
        ST_READ_HI: begin
          state <= ST_READ_LO;
        end
        ST_READ_LO: begin
          state <= ST_START;
        end
        ST_START: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Others stay blocked from grant until the routine starts
  always_ff @(posedge clock) begin
    if (!rst_b || basicTimerReset) begin
      intBlocked <= 1'b0;
    end else begin
      intBlocked <= (state == ST_IDLE && irqRequest && irqAck
        && systemMode[SYM_GLOBAL_EN]) || (state != ST_IDLE && state != ST_START); // R7
    end
  end

  // Vector table reads; the ROM answers one cycle after the address
  always_ff @(posedge clock) begin
    if (!rst_b || basicTimerReset) begin
      romRead <= 1'b0;
      romAddr <= 16'h0000;
      addrHi <= 8'h00;
    end else begin
      romRead <= 1'b0;
      if (state == ST_PUSH && stackDone) begin
        romRead <= 1'b1;
        romAddr <= {8'h00, grantVector}; // R8
      end else if (state == ST_READ_HI) begin
        romRead <= 1'b1;
        romAddr <= {8'h00, 8'(grantVector + 8'h01)}; // R8
      end
      if (state == ST_READ_LO) begin
        addrHi <= romData;
      end
    end
  end

  // Program counter load: reset start, or routine start from the vector bytes
  always_ff @(posedge clock) begin
    if (!rst_b || basicTimerReset) begin
      bootPending <= 1'b1;
      pcLoad <= 1'b0;
      pcValue <= RESET_VECTOR;
    end else if (bootPending) begin
      bootPending <= 1'b0;
      pcLoad <= 1'b1;
      pcValue <= RESET_VECTOR; // R9
    end else if (state == ST_START) begin
      pcLoad <= 1'b1;
      pcValue <= {addrHi, romData}; // R8
    end else begin
      pcLoad <= 1'b0;
    end
  end
endmodule

// [level_vector_interrupt_router_tb_top.sv]
`timescale 1ns/1ps
module level_vector_interrupt_router_tb_top
  import lvir_pkg::*;
;
  // Stimulus
  logic clock = 1'b0, rst_b = 1'b0, basicTimerReset = 1'b0, ackOn = 1'b0;
  logic maskWrite = 1'b0, priorityWrite = 1'b0, globalEnableInstr = 1'b0;
  logic globalDisableInstr = 1'b0, modeWrite = 1'b0;
  logic [4:0] modeData = 5'h00;
  logic [3:0] periphEvent = 4'h0, stackDelay = 4'h0;
  logic [11:0] sourceEnable = 12'hfff, pendingClear = 12'h000;
  logic [7:0] extPin = 8'h00, maskData = 8'h00, pinEdge = 8'hff;
  logic [23:0] priorityData = 24'h000000;
  // Responses
  logic irqAck, stackDone, irqRequest, intBlocked, romRead, pcLoad;
  logic [7:0] romData, levelMask, levelRequest, irqVector;
  logic [23:0] levelPriority;
  logic [4:0] systemMode;
  logic [11:0] sourcePending;
  logic [2:0] irqLevel;
  logic [15:0] romAddr, pcValue;
  int fail_count = 0, checked = 0, cycles = 0;
  // Vector and level of each source, in port index order
  logic [7:0] vecTab [12] = '{8'hf0, 8'hf2, 8'hf4, 8'hf6, 8'he0, 8'he2, 8'he4, 8'he6,
    8'he8, 8'hea, 8'hec, 8'hee};
  logic [2:0] lvlTab [12] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6,
    3'h7, 3'h7, 3'h7, 3'h7};

  level_vector_interrupt_router dut (.clock, .rst_b, .basicTimerReset, .periphEvent,
    .sourceEnable, .pendingClear, .extPin, .pinRisingEdge(pinEdge), .maskWrite, .maskData,
    .priorityWrite, .priorityData, .modeWrite, .modeData, .globalEnableInstr,
    .globalDisableInstr, .irqAck, .stackDone, .romData, .levelMask, .levelPriority,
    .systemMode, .levelRequest, .sourcePending, .irqRequest, .irqVector, .irqLevel,
    .intBlocked, .romRead, .romAddr, .pcLoad, .pcValue);
  lvir_core_model core (.clock, .ackOn, .stackDelay, .irqRequest, .romRead, .romAddr,
    .irqAck, .stackDone, .romData);

  // 250 MHz clock
  initial begin
    forever #2 clock = ~clock;
  end

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic compare(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One-cycle strobes; outputs settle within three cycles
  task automatic ctl(input logic en, input logic dis, input logic wr, input logic [7:0] m,
    input logic [23:0] p);
    @(posedge clock);
    {globalEnableInstr, globalDisableInstr, maskWrite, priorityWrite} <= {en, dis, wr, wr};
    maskData <= m;
    priorityData <= p;
    @(posedge clock);
    {globalEnableInstr, globalDisableInstr, maskWrite, priorityWrite} <= 4'h0;
    repeat (3) @(negedge clock);
  endtask

  // Raise source i; clr wipes all flags in the same cycle, so a peripheral event (i < 4) must win
  task automatic raise(input int i, input logic clr);
    @(posedge clock);
    pendingClear <= {12{clr}};
    if (i < 4) periphEvent[i] <= 1'b1;
    else extPin[i-4] <= 1'b1;
    @(posedge clock);
    {periphEvent, pendingClear} <= 16'h0000;
    repeat (6) @(posedge clock);
    extPin <= 8'h00;
    repeat (6) @(negedge clock);
  endtask

  // Bounded wait for the program counter load
  task automatic waitPc(input logic [15:0] exp);
    for (int n = 0; n < 40 && pcLoad !== 1'b1; n++) begin
      @(negedge clock);
    end
    compare(pcLoad, 1'b1);
    compare(pcValue, exp);
  endtask

  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    waitPc(RESET_VECTOR);
    compare(systemMode, 5'h00);
    ctl(1'b0, 1'b0, 1'b1, 8'hff, 24'hfac688);
    compare(levelMask, 8'hff);
    compare(levelPriority, 24'hfac688);
    raise(0, 1'b0);
    compare(levelRequest, 8'h01);
    compare(irqRequest, 1'b0);
    ctl(1'b1, 1'b0, 1'b0, 8'h00, 24'h000000);
    compare(irqRequest, 1'b1);
    for (int i = 11; i >= 0; i--) begin
      raise(i, 1'b1);
      compare(sourcePending, 12'h001 << i);
      compare(irqVector, vecTab[i]);
      compare(irqLevel, lvlTab[i]);
    end
    raise(11, 1'b1);
    raise(9, 1'b0);
    compare(irqVector, 8'hea);
    raise(1, 1'b0);
    compare(irqVector, 8'hf2);
    raise(0, 1'b0);
    compare(irqVector, 8'hf0);
    ctl(1'b0, 1'b0, 1'b1, 8'hff, 24'h1ac68f);
    compare(irqVector, 8'hea);
    ctl(1'b0, 1'b0, 1'b1, 8'h7f, 24'h1ac68f);
    compare(irqLevel, 3'h0);
    for (int d = 0; d < 2; d++) begin
      @(posedge clock);
      stackDelay <= 4'(d * 9);
      ackOn <= 1'b1;
      waitPc(16'haaab);
      compare(intBlocked, 1'b0);
      @(posedge clock);
      ackOn <= 1'b0;
    end
    ctl(1'b0, 1'b1, 1'b0, 8'h00, 24'h000000);
    compare(irqRequest, 1'b0);
    ctl(1'b1, 1'b0, 1'b0, 8'h00, 24'h000000);
    compare(systemMode, 5'h01);
    // Plain mode write sets the fast bits so the timer reset has something to clear
    @(posedge clock);
    modeWrite <= 1'b1;
    modeData <= 5'h1e;
    @(posedge clock);
    modeWrite <= 1'b0;
    repeat (3) @(negedge clock);
    compare(systemMode, 5'h1e);
    @(posedge clock);
    basicTimerReset <= 1'b1;
    @(posedge clock);
    basicTimerReset <= 1'b0;
    waitPc(RESET_VECTOR);
    compare(systemMode, 5'h00);
    compare(sourcePending, 12'ha03);
    // Falling edge mode on the first pin: only the release of the pin counts
    @(posedge clock);
    pinEdge <= 8'hfe;
    raise(4, 1'b1);
    compare(sourcePending, 12'h010);
    compare(levelRequest, 8'h08);
    // A disabled source keeps its flag but no longer raises its level
    @(posedge clock);
    sourceEnable <= 12'hfef;
    repeat (3) @(negedge clock);
    compare(levelRequest, 8'h00);
    summarize();
  end
endmodule

// [lvir_assertions.sv]
`timescale 1ns/1ps
module lvir_assertions
  import lvir_pkg::*;
(
  // Clock and resets
  input wire logic clock,
  input wire logic rst_b,
  input wire logic basicTimerReset,
  // Inputs
  input wire logic [NUM_SRC-1:0] sourceEnable,
  input wire logic globalDisableInstr,
  input wire logic [7:0] romData,
  // Outputs
  input wire logic [NUM_LVL-1:0] levelMask,
  input wire logic [SYM_W-1:0] systemMode,
  input wire logic [NUM_LVL-1:0] levelRequest,
  input wire logic [NUM_SRC-1:0] sourcePending,
  input wire logic irqRequest,
  input wire logic [2:0] irqLevel,
  input wire logic intBlocked,
  input wire logic romRead,
  input wire logic [15:0] romAddr,
  input wire logic pcLoad,
  input wire logic [15:0] pcValue
);
  // Last cycle's inputs to the registered outputs, which lag by one cycle
  logic [NUM_LVL-1:0] liveLast;
  logic [NUM_SRC-1:0] pendOn;
  always_ff @(posedge clock) begin
    liveLast <= levelMask & levelRequest;
    pendOn <= sourcePending & sourceEnable;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // Both vector bytes read back to back
  sequence fetchPair;
    romRead ##1 (romRead && romAddr == $past(romAddr) + 16'h0001);
  endsequence

  chk_disabled_quiet: assert property (!systemMode[SYM_GLOBAL_EN] |=> !irqRequest)
    else $error("request while globally disabled");
  chk_live_level: assert property (irqRequest |-> liveLast[irqLevel])
    else $error("request for a masked or idle level");
  chk_block_quiet: assert property (intBlocked |-> !irqRequest)
    else $error("request while blocked");
  chk_pc_start: assert property (fetchPair |-> ##2 (pcLoad && !intBlocked
    && pcValue == {$past(romData, 2), $past(romData, 1)}))
    else $error("start address not formed from vector bytes");
  chk_reset_start: assert property ($rose(rst_b) |=> pcLoad && pcValue == RESET_VECTOR)
    else $error("no start at reset address");
  chk_timer_reset: assert property (basicTimerReset |-> ##[1:2] (pcLoad
    && pcValue == RESET_VECTOR && systemMode[1:0] == 2'b00))
    else $error("timer reset did not restart");
  chk_disable_now: assert property (globalDisableInstr |=> !systemMode[SYM_GLOBAL_EN])
    else $error("disable not taken");
  chk_level_or: assert property (levelRequest == {|pendOn[11:8], pendOn[7:2],
    |pendOn[1:0]})
    else $error("level flags differ from sources");
endmodule
bind level_vector_interrupt_router lvir_assertions chk (.clock, .rst_b, .basicTimerReset,
  .sourceEnable, .globalDisableInstr, .romData, .levelMask, .systemMode, .levelRequest,
  .sourcePending, .irqRequest, .irqLevel, .intBlocked, .romRead, .romAddr, .pcLoad,
  .pcValue);

// [lvir_core_model.sv]
`timescale 1ns/1ps
module lvir_core_model (
  // Clock and test controls
  input wire logic clock,
  input wire logic ackOn,
  input wire logic [3:0] stackDelay,
  // Router side
  input wire logic irqRequest,
  input wire logic romRead,
  input wire logic [15:0] romAddr,
  output logic irqAck,
  output logic stackDone,
  output logic [7:0] romData
);
  logic busy = 1'b0;
  logic [3:0] cnt = 4'h0;
  // Core: grant, push for stackDelay plus one cycles; ROM byte is address xor 5a,
  // and between reads the data bus wanders so stale bytes never look valid
  always @(posedge clock) begin
    irqAck <= ackOn && irqRequest && !irqAck && !busy;
    stackDone <= busy && cnt == 4'h0;
    if (irqAck) begin
      busy <= 1'b1;
      cnt <= stackDelay;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else begin
      busy <= 1'b0;
    end
    romData <= romRead ? romAddr[7:0] ^ 8'h5a : ~romData;
  end
endmodule

// [lvir_level_pick.sv]
`timescale 1ns/1ps
module lvir_level_pick
  import lvir_pkg::*;
(
  // Levels that may win and their ranks
  input wire logic [NUM_LVL-1:0] request,
  input wire logic [NUM_LVL*RANK_W-1:0] rank,
  // Winning level
  output logic valid,
  output logic [2:0] level
);
  logic [RANK_W-1:0] bestRank;

  // Lowest rank wins; equal ranks fall to the lower level number
  always_comb begin
    valid = 1'b0;
    level = 3'h0;
    bestRank = '1;
    for (int i = 0; i < NUM_LVL; i++) begin
      if (request[i] && (!valid || rank[i*RANK_W +: RANK_W] < bestRank)) begin
        valid = 1'b1;
        level = 3'(i);
        bestRank = rank[i*RANK_W +: RANK_W];
      end
    end
  end
endmodule

// [lvir_pkg.sv]
package lvir_pkg;
  // Sizes of the interrupt structure
  localparam int NUM_SRC = 12;
  localparam int NUM_LVL = 8;
  localparam int RANK_W = 3;

  // Program start after any reset
  localparam logic [15:0] RESET_VECTOR = 16'h0100;

  // Vector addresses of the sources
  localparam logic [7:0] VEC_TIMER_A = 8'hf0;
  localparam logic [7:0] VEC_TIMER_B = 8'hf2;
  localparam logic [7:0] VEC_SERIAL = 8'hf4;
  localparam logic [7:0] VEC_WATCH = 8'hf6;
  localparam logic [7:0] VEC_PIN_BASE = 8'he0;
  localparam logic [7:0] VEC_STEP = 8'h02;

  // Source index layout: 0 timer A, 1 timer B, 2 serial, 3 watch, 4..11 pins
  localparam logic [3:0] SRC_TIMER_A = 4'h0;
  localparam logic [3:0] SRC_TIMER_B = 4'h1;
  localparam logic [3:0] SRC_SERIAL = 4'h2;
  localparam logic [3:0] SRC_WATCH = 4'h3;
  localparam logic [3:0] SRC_PIN0 = 4'h4;
  localparam logic [3:0] SRC_SHARED_PIN = 4'h8;

  // System mode register fields
  localparam int SYM_W = 5;
  localparam int SYM_GLOBAL_EN = 0;
  localparam int SYM_FAST_EN = 1;
  localparam logic [SYM_W-1:0] SYM_RESET = 5'h00;

  // Level mask and level priority reset values
  localparam logic [NUM_LVL-1:0] MASK_RESET = 8'h00;
  localparam logic [NUM_LVL*RANK_W-1:0] PRIO_RESET = 24'hfac688;

  // Controller sequence
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PUSH = 3'b001,
    ST_READ_HI = 3'b010,
    ST_READ_LO = 3'b011,
    ST_START = 3'b100
  } lvir_state_t;

  // Level that a source belongs to
  function automatic logic [2:0] lvir_level_of(input logic [3:0] src);
    if (src <= SRC_TIMER_B) begin
      return 3'h0;
    end else if (src >= SRC_SHARED_PIN) begin
      return 3'h7;
    end else begin
      return 3'(src - 4'h1);
    end
  endfunction

  // Vector address of a source
  function automatic logic [7:0] lvir_vector_of(input logic [3:0] src);
    case (src)
      SRC_TIMER_A: return VEC_TIMER_A;
      SRC_TIMER_B: return VEC_TIMER_B;
      SRC_SERIAL: return VEC_SERIAL;
      SRC_WATCH: return VEC_WATCH;
      default: return 8'(VEC_PIN_BASE + 8'(src - SRC_PIN0) * VEC_STEP);
    endcase
  endfunction
endpackage
